// ---- design/stu_pkg.sv ----
package stu_pkg;

  // ****************************************************************
  // Register map, byte addresses of 32-bit words on the plain register port
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_MASK     = 8'h08;
  localparam logic [7:0] ADDR_LOAD_0   = 8'h10;
  localparam logic [7:0] ADDR_COUNT_0  = 8'h30;
  localparam logic [7:0] ADDR_CMP_0    = 8'h50;
  localparam logic [7:0] ADDR_WD_LOAD  = 8'h60;
  localparam logic [7:0] ADDR_WD_CMP   = 8'h64;
  localparam logic [7:0] ADDR_WD_COUNT = 8'h68;
  localparam logic [7:0] ADDR_WD_CTRL  = 8'h6c;

  // ****************************************************************
  // Sizes, fields and reset values
  // ****************************************************************
  localparam int          NUM_TIMERS    = 5;
  localparam int          NUM_CMP       = 4;
  localparam int          CMP_TIMER     = 2;
  localparam int          CTRL_EN_LSB   = 0;
  localparam int          CTRL_CONT_LSB = 8;
  localparam int          CTRL_CMPEN_LSB = 16;
  localparam int          STAT_WD_BIT   = 5;
  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
  localparam logic [31:0] WD_LOAD_RESET = 32'hffff_ffff;
  localparam logic [31:0] CNT_MAX       = 32'hffff_ffff;
  localparam logic [31:0] CNT_ZERO      = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE       = 32'h0000_0001;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } stu_bus_req_t;

endpackage : stu_pkg

// ---- design/stu_down_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

// One loadable down-counter, used for timers 0, 1, 3 and 4.
module stu_down_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        load_i,
  input  wire logic [31:0] load_value_i,
  input  wire logic        enable_i,
  input  wire logic        continuous_i,
  output logic [31:0]      count_o,
  output logic             expire_o
);

  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic        expire_reg;
  logic        expire_next;

  always_comb
  begin
    count_next  = count_reg;
    expire_next = 1'b0;
    if (load_i)
    begin
      count_next = load_value_i;
    end
    else if (enable_i && count_reg == stu_pkg::CNT_ONE)
    begin
      count_next  = stu_pkg::CNT_ZERO; // R4
      expire_next = 1'b1;              // R4
    end
    else if (enable_i && count_reg == stu_pkg::CNT_ZERO)
    begin
      // Single-shot holds at zero; continuous reloads next cycle.
      if (continuous_i)
      begin
        count_next = load_value_i; // R11
      end
    end
    else if (enable_i)
    begin
      count_next = count_reg - stu_pkg::CNT_ONE; // R2
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_reg  <= stu_pkg::RESET_WORD;
      expire_reg <= 1'b0;
    end
    else
    begin
      count_reg  <= count_next;
      expire_reg <= expire_next;
    end
  end

  assign count_o  = count_reg;
  assign expire_o = expire_reg;

  a_zero_hold: assert property ( // R3
    @(posedge clk_i) disable iff (!rst_n_i)
    (enable_i && !continuous_i && !load_i && count_reg == 32'h0)
    |=> (count_reg == 32'h0))
    else $error("single-shot timer left zero without load");

  a_cont_reload: assert property ( // R11
    @(posedge clk_i) disable iff (!rst_n_i)
    (enable_i && continuous_i && !load_i && count_reg == 32'h0)
    |=> (count_reg == $past(load_value_i)))
    else $error("continuous timer did not reload");

  a_expire_zero: assert property ( // R4
    @(posedge clk_i) disable iff (!rst_n_i)
    expire_reg |-> (count_reg == 32'h0 || $past(load_i)))
    else $error("expiry without zero count");

endmodule : stu_down_timer

`default_nettype wire

// ---- design/stu_timer_unit.sv ----
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: five timers plus one watchdog counter.
// R2: timers 0,1,3,4 count down from load.
// R3: per-timer single-shot or continuous mode select.
// R4: down timer interrupts on reaching zero.
// R5: timer 2 holds four compare values.
// R6: timer 2 interrupts on enabled compare match.
// R7: watchdog loads start value, counts down.
// R8: firmware reloads watchdog before zero.
// R9: watchdog at zero resets whole device.
// R10: watchdog compare match gives warning interrupt.
// R11: continuous reloads after zero; single-shot holds.
// R12: timer 2 counts up, wraps or stops.
module stu_timer_unit (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic [31:0]      RDATA_O,
  output logic             IRQ_O,
  output logic             WD_WARN_O,
  output logic             DEVICE_RESET_O
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  stu_pkg::stu_bus_req_t req;
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [5:0]  status_reg;
  logic [5:0]  status_next;
  logic [5:0]  mask_reg;
  logic [5:0]  mask_next;
  logic [31:0] load_reg [stu_pkg::NUM_TIMERS];
  logic [31:0] load_next [stu_pkg::NUM_TIMERS];
  logic [31:0] cmp_reg [stu_pkg::NUM_CMP];
  logic [31:0] cmp_next [stu_pkg::NUM_CMP];
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] count [stu_pkg::NUM_TIMERS];
  logic [4:0]  expire;
  logic [4:0]  load_pulse;
  logic [31:0] up_reg;
  logic [31:0] up_next;
  logic        up_done_reg;
  logic        up_done_next;
  logic        up_match_reg;
  logic        up_match_next;
  logic [31:0] wd_load_reg;
  logic [31:0] wd_load_next;
  logic [31:0] wd_cmp_reg;
  logic [31:0] wd_cmp_next;
  logic [31:0] wd_cnt_reg;
  logic [31:0] wd_cnt_next;
  logic        wd_en_reg;
  logic        wd_en_next;
  logic        wd_fire_reg;
  logic        wd_fire_next;
  logic        wd_warn;
  logic [3:0]  cmp_hit;
  logic [3:0]  cmp_en;
  logic [3:0]  cmp_last;
  logic        up_en;
  logic        up_cont;

  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
  assign up_en   = ctrl_reg[stu_pkg::CTRL_EN_LSB + stu_pkg::CMP_TIMER];
  assign up_cont = ctrl_reg[stu_pkg::CTRL_CONT_LSB + stu_pkg::CMP_TIMER];
  assign cmp_en  = ctrl_reg[stu_pkg::CTRL_CMPEN_LSB +: stu_pkg::NUM_CMP];

  // ****************************************************************
  // Timer instances: down-counters, with timer 2 taken from the up-counter
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < stu_pkg::NUM_TIMERS; g++)
    begin : g_tmr
      assign load_pulse[g] = req.wr
        && req.addr == stu_pkg::ADDR_LOAD_0 + 8'(4 * g);
      if (g != stu_pkg::CMP_TIMER)
      begin : g_down
        stu_down_timer u_down ( // R1 R2
          .clk_i        (SYS_CLK_I),
          .rst_n_i      (RESET_N_I),
          .load_i       (load_pulse[g]),
          .load_value_i (load_pulse[g] ? req.wdata : load_reg[g]),
          .enable_i     (ctrl_reg[stu_pkg::CTRL_EN_LSB + g]),
          .continuous_i (ctrl_reg[stu_pkg::CTRL_CONT_LSB + g]), // R3
          .count_o      (count[g]),
          .expire_o     (expire[g])
        );
      end
      else
      begin : g_up
        assign count[g]  = up_reg;
        assign expire[g] = up_match_reg;
      end
    end
  endgenerate

  // ****************************************************************
  // Timer 2: up-counter with four compare slots
  // ****************************************************************
  always_comb
  begin
    for (int i = 0; i < stu_pkg::NUM_CMP; i++)
    begin
      cmp_hit[i]  = cmp_en[i] && up_reg == cmp_reg[i]; // R5 R6
      cmp_last[i] = cmp_en[i];
      for (int j = 0; j < stu_pkg::NUM_CMP; j++)
      begin
        if (cmp_en[j] && cmp_reg[j] > cmp_reg[i])
          cmp_last[i] = 1'b0;
      end
    end
  end

  always_comb
  begin
    up_next       = up_reg;
    up_done_next  = up_done_reg;
    up_match_next = 1'b0;
    if (load_pulse[stu_pkg::CMP_TIMER])
    begin
      up_next      = stu_pkg::CNT_ZERO;
      up_done_next = 1'b0;
    end
    else if (up_en && !up_done_reg)
    begin
      up_match_next = |cmp_hit; // R6
      // Single-shot stops at the highest enabled compare value.
      if (!up_cont && |(cmp_hit & cmp_last))
      begin
        up_done_next = 1'b1; // R12
      end
      else
      begin
        up_next = up_reg + stu_pkg::CNT_ONE; // R12
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      up_reg       <= stu_pkg::RESET_WORD;
      up_done_reg  <= 1'b0;
      up_match_reg <= 1'b0;
    end
    else
    begin
      up_reg       <= up_next;
      up_done_reg  <= up_done_next;
      up_match_reg <= up_match_next;
    end
  end

  a_up_match: assert property ( // R6
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (up_en && !up_done_reg && !load_pulse[2] && |cmp_hit)
    |=> up_match_reg)
    else $error("timer 2 compare match missed");

  a_up_wrap: assert property ( // R12
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (up_en && up_cont && !up_done_reg && !load_pulse[2])
    |=> up_reg == $past(up_reg) + 32'h1)
    else $error("timer 2 did not count on or wrap");

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  assign wd_warn = wd_en_reg && wd_cnt_reg == wd_cmp_reg
    && wd_cnt_reg != stu_pkg::CNT_ZERO;

  always_comb
  begin
    wd_cnt_next  = wd_cnt_reg;
    wd_fire_next = 1'b0;
    if (req.wr && req.addr == stu_pkg::ADDR_WD_LOAD)
      wd_cnt_next = req.wdata; // R7 R8
    else if (wd_en_reg && wd_cnt_reg != stu_pkg::CNT_ZERO)
      wd_cnt_next = wd_cnt_reg - stu_pkg::CNT_ONE; // R7
    else if (wd_en_reg)
      wd_fire_next = 1'b1; // R9
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      wd_cnt_reg  <= stu_pkg::WD_LOAD_RESET;
      wd_fire_reg <= 1'b0;
    end
    else
    begin
      wd_cnt_reg  <= wd_cnt_next;
      wd_fire_reg <= wd_fire_next;
    end
  end

  a_wd_reset: assert property ( // R9
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (wd_en_reg && wd_cnt_reg == 32'h0
      && !(WR_I && ADDR_I == stu_pkg::ADDR_WD_LOAD))
    |=> DEVICE_RESET_O)
    else $error("watchdog zero did not reset device");

  a_wd_warn: assert property ( // R10
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    wd_warn |=> status_reg[stu_pkg::STAT_WD_BIT])
    else $error("watchdog warning not flagged");

  // ****************************************************************
  // Register file and interrupts
  // ****************************************************************
  always_comb
  begin
    ctrl_next    = ctrl_reg;
    mask_next    = mask_reg;
    wd_load_next = wd_load_reg;
    wd_cmp_next  = wd_cmp_reg;
    wd_en_next   = wd_en_reg;
    status_next  = status_reg;
    load_next    = load_reg;
    cmp_next     = cmp_reg;
    rdata_next   = stu_pkg::RESET_WORD;
    if (req.wr)
    begin
      case (req.addr)
        stu_pkg::ADDR_CTRL:    ctrl_next    = req.wdata;
        stu_pkg::ADDR_MASK:    mask_next    = req.wdata[5:0];
        stu_pkg::ADDR_STATUS:  status_next  = status_reg & ~req.wdata[5:0];
        stu_pkg::ADDR_WD_LOAD: wd_load_next = req.wdata;
        stu_pkg::ADDR_WD_CMP:  wd_cmp_next  = req.wdata; // R10
        stu_pkg::ADDR_WD_CTRL: wd_en_next   = wd_en_reg | req.wdata[0];
        default:               ctrl_next    = ctrl_reg;
      endcase
      for (int i = 0; i < stu_pkg::NUM_TIMERS; i++)
      begin
        if (load_pulse[i])
          load_next[i] = req.wdata;
      end
      for (int i = 0; i < stu_pkg::NUM_CMP; i++)
      begin
        if (req.addr == stu_pkg::ADDR_CMP_0 + 8'(4 * i))
          cmp_next[i] = req.wdata; // R5
      end
    end
    // Set wins over a clear written in the same cycle.
    status_next = status_next | {wd_warn, expire}; // R4 R10
    if (req.rd)
    begin
      case (req.addr)
        stu_pkg::ADDR_CTRL:     rdata_next = ctrl_reg;
        stu_pkg::ADDR_STATUS:   rdata_next = {26'h0, status_reg};
        stu_pkg::ADDR_MASK:     rdata_next = {26'h0, mask_reg};
        stu_pkg::ADDR_WD_LOAD:  rdata_next = wd_load_reg;
        stu_pkg::ADDR_WD_CMP:   rdata_next = wd_cmp_reg;
        stu_pkg::ADDR_WD_COUNT: rdata_next = wd_cnt_reg;
        stu_pkg::ADDR_WD_CTRL:  rdata_next = {31'h0, wd_en_reg};
        default:                rdata_next = stu_pkg::RESET_WORD;
      endcase
      for (int i = 0; i < stu_pkg::NUM_TIMERS; i++)
      begin
        if (req.addr == stu_pkg::ADDR_LOAD_0 + 8'(4 * i))
          rdata_next = load_reg[i];
        if (req.addr == stu_pkg::ADDR_COUNT_0 + 8'(4 * i))
          rdata_next = count[i];
      end
      for (int i = 0; i < stu_pkg::NUM_CMP; i++)
      begin
        if (req.addr == stu_pkg::ADDR_CMP_0 + 8'(4 * i))
          rdata_next = cmp_reg[i];
      end
    end
  end

  // The watchdog enable is sticky so runaway firmware cannot stop it.
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      ctrl_reg    <= stu_pkg::RESET_WORD;
      mask_reg    <= 6'h00;
      status_reg  <= 6'h00;
      wd_load_reg <= stu_pkg::WD_LOAD_RESET;
      wd_cmp_reg  <= stu_pkg::RESET_WORD;
      wd_en_reg   <= 1'b0;
      rdata_reg   <= stu_pkg::RESET_WORD;
      for (int i = 0; i < stu_pkg::NUM_TIMERS; i++)
      begin
        load_reg[i] <= stu_pkg::RESET_WORD;
      end
      for (int i = 0; i < stu_pkg::NUM_CMP; i++)
      begin
        cmp_reg[i] <= stu_pkg::RESET_WORD;
      end
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      mask_reg    <= mask_next;
      status_reg  <= status_next;
      wd_load_reg <= wd_load_next;
      wd_cmp_reg  <= wd_cmp_next;
      wd_en_reg   <= wd_en_next;
      rdata_reg   <= rdata_next;
      load_reg    <= load_next;
      cmp_reg     <= cmp_next;
    end
  end

  a_irq_level: assert property ( // R4
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (|(expire & mask_reg[4:0])
      && !(WR_I && ADDR_I == stu_pkg::ADDR_MASK))
    |=> IRQ_O)
    else $error("unmasked expiry did not raise interrupt");

  a_status_sticky: assert property ( // R4
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (status_reg[1] && !(WR_I && ADDR_I == stu_pkg::ADDR_STATUS && WDATA_I[1]))
    |=> status_reg[1])
    else $error("status bit dropped without clear");

  assign RDATA_O        = rdata_reg;
  assign IRQ_O          = |(status_reg & mask_reg);
  assign WD_WARN_O      = status_reg[stu_pkg::STAT_WD_BIT];
  assign DEVICE_RESET_O = wd_fire_reg; // R9

endmodule : stu_timer_unit

`default_nettype wire

// ---- verification/stu_fw_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Firmware side of the register port
// ****************************************************************
// Strobes rise one edge after the task is entered and fall at the next
// edge, so two calls in a row always leave an idle cycle between them.
module stu_fw_model (
  input  wire logic                 clk_i,
  input  wire logic [31:0]          rdata_i,
  output var  stu_pkg::stu_bus_req_t req_o
);

  initial
  begin
    req_o = '0;
  end

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_i);
    req_o.addr  <= addr;
    req_o.wdata <= data;
    req_o.wr    <= 1'b1;
    @(posedge clk_i);
    req_o.wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken
  // at the falling edge inside that cycle, clear of the next update.
  task automatic rd(input logic [7:0] addr, output logic [31:0] data);
    @(posedge clk_i);
    req_o.addr <= addr;
    req_o.rd   <= 1'b1;
    @(posedge clk_i);
    req_o.rd   <= 1'b0;
    @(negedge clk_i);
    data = rdata_i;
  endtask : rd

  // Rewriting the start value keeps the watchdog away from zero.
  task automatic kick(input logic [31:0] start);
    wr(stu_pkg::ADDR_WD_LOAD, start);
  endtask : kick

endmodule : stu_fw_model

`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;

  logic                  sys_clk;
  logic                  reset_n;
  logic [31:0]           rdata;
  logic                  irq;
  logic                  wd_warn;
  logic                  dev_rst;
  stu_pkg::stu_bus_req_t req;
  int                    err_total = 0;
  int                    tests_run = 0;

  stu_fw_model fw_u (
    .clk_i   (sys_clk),
    .rdata_i (rdata),
    .req_o   (req)
  );

  stu_timer_unit dut_u (
    .SYS_CLK_I      (sys_clk),
    .RESET_N_I      (reset_n),
    .ADDR_I         (req.addr),
    .WDATA_I        (req.wdata),
    .WR_I           (req.wr),
    .RD_I           (req.rd),
    .RDATA_O        (rdata),
    .IRQ_O          (irq),
    .WD_WARN_O      (wd_warn),
    .DEVICE_RESET_O (dev_rst)
  );

  // ****************************************************************
  // Clock, reset and common helpers
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic chk_reg(input string what, input logic [7:0] addr,
                         input logic [31:0] exp);
    logic [31:0] d;
    fw_u.rd(addr, d);
    chk(what, exp, d);
  endtask : chk_reg

  task automatic summarize();
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_values();
    chk_reg("ctrl", stu_pkg::ADDR_CTRL, 32'h0000_0000);
    chk_reg("status", stu_pkg::ADDR_STATUS, 32'h0000_0000);
    chk_reg("mask", stu_pkg::ADDR_MASK, 32'h0000_0000);
    chk_reg("wd count", stu_pkg::ADDR_WD_COUNT, 32'hffff_ffff);
    chk_reg("unmapped", 8'hfc, 32'h0000_0000);
    chk("dev reset idle", 32'h0, {31'h0, dev_rst});
  endtask : t_reset_values

  // Each down timer in single-shot mode, with its interrupt path.
  task automatic t_single_shot();
    logic [31:0] bit_n;
    for (int n = 0; n < stu_pkg::NUM_TIMERS; n++)
    begin
      if (n != stu_pkg::CMP_TIMER)
      begin
        bit_n = 32'h0000_0001 << n;
        fw_u.wr(stu_pkg::ADDR_CTRL, bit_n);
        fw_u.wr(stu_pkg::ADDR_LOAD_0 + 8'(4 * n), 32'h0000_0004);
        repeat (12) @(posedge sys_clk);
        chk_reg("count held", stu_pkg::ADDR_COUNT_0 + 8'(4 * n),
                32'h0000_0000);
        chk_reg("event", stu_pkg::ADDR_STATUS, bit_n);
        chk("irq masked", 32'h0, {31'h0, irq});
        fw_u.wr(stu_pkg::ADDR_MASK, bit_n);
        @(negedge sys_clk);
        chk("irq on", 32'h1, {31'h0, irq});
        fw_u.wr(stu_pkg::ADDR_STATUS, bit_n);
        @(negedge sys_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        fw_u.wr(stu_pkg::ADDR_MASK, 32'h0000_0000);
      end
    end
    fw_u.wr(stu_pkg::ADDR_CTRL, 32'h0000_0000);
  endtask : t_single_shot

  // Continuous mode keeps reloading, so two reads never both sit at zero.
  task automatic t_continuous();
    logic [31:0] a;
    logic [31:0] b;
    fw_u.wr(stu_pkg::ADDR_MASK, 32'h0000_0002);
    fw_u.wr(stu_pkg::ADDR_CTRL, 32'h0000_0202);
    fw_u.wr(stu_pkg::ADDR_LOAD_0 + 8'h04, 32'h0000_0005);
    repeat (30) @(posedge sys_clk);
    fw_u.rd(stu_pkg::ADDR_COUNT_0 + 8'h04, a);
    fw_u.rd(stu_pkg::ADDR_COUNT_0 + 8'h04, b);
    chk("reload bound", 32'h1, {31'h0, a <= 32'h5 && b <= 32'h5});
    chk("keeps running", 32'h1, {31'h0, a !== b});
    chk("cont irq", 32'h1, {31'h0, irq});
    chk_reg("cont event", stu_pkg::ADDR_STATUS, 32'h0000_0002);
    fw_u.wr(stu_pkg::ADDR_CTRL, 32'h0000_0000);
    fw_u.wr(stu_pkg::ADDR_STATUS, 32'h0000_003f);
    fw_u.wr(stu_pkg::ADDR_MASK, 32'h0000_0000);
  endtask : t_continuous

  task automatic t_compare_timer();
    logic [31:0] c;
    fw_u.wr(stu_pkg::ADDR_CMP_0, 32'h0000_0003);
    fw_u.wr(stu_pkg::ADDR_CMP_0 + 8'h04, 32'h0000_0007);
    fw_u.wr(stu_pkg::ADDR_CMP_0 + 8'h08, 32'h0000_0100);
    fw_u.wr(stu_pkg::ADDR_CTRL, 32'h0003_0004);
    fw_u.wr(stu_pkg::ADDR_LOAD_0 + 8'h08, 32'h0000_0000);
    repeat (20) @(posedge sys_clk);
    chk_reg("t2 stop", stu_pkg::ADDR_COUNT_0 + 8'h08, 32'h0000_0007);
    chk_reg("t2 event", stu_pkg::ADDR_STATUS, 32'h0000_0004);
    fw_u.wr(stu_pkg::ADDR_CTRL, 32'h0003_0404);
    // A stopped single-shot run only restarts through its load write.
    fw_u.wr(stu_pkg::ADDR_LOAD_0 + 8'h08, 32'h0000_0000);
    repeat (20) @(posedge sys_clk);
    fw_u.rd(stu_pkg::ADDR_COUNT_0 + 8'h08, c);
    chk("t2 runs on", 32'h0000_0015, c);
    fw_u.wr(stu_pkg::ADDR_CTRL, 32'h0000_0000);
    fw_u.wr(stu_pkg::ADDR_STATUS, 32'h0000_003f);
  endtask : t_compare_timer

  // The warning must come about twenty cycles before the device reset.
  task automatic t_watchdog();
    int warn_at;
    int rst_at;
    warn_at = -1;
    rst_at  = -1;
    fw_u.wr(stu_pkg::ADDR_WD_CMP, 32'h0000_0014);
    fw_u.kick(32'h0000_0028);
    fw_u.wr(stu_pkg::ADDR_WD_CTRL, 32'h0000_0001);
    repeat (4) fw_u.kick(32'h0000_0028);
    chk("wd no reset", 32'h0, {31'h0, dev_rst | wd_warn});
    for (int k = 0; k < 100 && rst_at < 0; k++)
    begin
      @(negedge sys_clk);
      if (wd_warn === 1'b1 && warn_at < 0)
        warn_at = k;
      if (dev_rst === 1'b1)
        rst_at = k;
    end
    chk("wd fired", 32'h1, {31'h0, rst_at > 0});
    chk("warn gap", 32'h1, {31'h0, rst_at - warn_at inside {[19:21]}});
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    chk("reset recovers", 32'h0, {31'h0, dev_rst});
    chk_reg("wd count again", stu_pkg::ADDR_WD_COUNT, 32'hffff_ffff);
  endtask : t_watchdog

  // ****************************************************************
  // Main sequence and watchdog on the run itself
  // ****************************************************************
  initial
  begin
    reset_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset_values();
    t_single_shot();
    t_continuous();
    t_compare_timer();
    t_watchdog();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    summarize();
  end

endmodule : tb_top

`default_nettype wire
